//--- include/asp_pkg.sv
// Purpose: Shared constants for the asynchronous serial port block
// Assumes: 100 MHz system clock, AXI4-Lite register access
// Notes: Offsets are byte addresses of 32-bit registers
package asp_pkg;
   localparam logic [7:0] ASP_CTRL_OFS = 8'h00;
   localparam logic [7:0] ASP_BAUD_OFS = 8'h04;
   localparam logic [7:0] ASP_TXDATA_OFS = 8'h08;
   localparam logic [7:0] ASP_RXDATA_OFS = 8'h0c;
   localparam logic [7:0] ASP_STAT_OFS = 8'h10;
   localparam logic [7:0] ASP_IRQ_OFS = 8'h14;
   localparam logic [7:0] ASP_MASK_OFS = 8'h18;
   // Control fields
   localparam int ASP_C_BITS7 = 0;
   localparam int ASP_C_PAR_EN = 1;
   localparam int ASP_C_PAR_ODD = 2;
   localparam int ASP_C_STOP2 = 3;
   localparam int ASP_C_FLOW = 4;
   localparam int ASP_C_DTR = 5;
   localparam int ASP_C_RI_WAKE = 6;
   localparam int ASP_C_SLEEP = 7;
   localparam int ASP_C_RTS = 8;
   localparam logic [8:0] ASP_CTRL_RST = 9'h110;
   // Interrupt status fields
   localparam int ASP_I_RXDONE = 0;
   localparam int ASP_I_TXDONE = 1;
   localparam int ASP_I_PARERR = 2;
   localparam int ASP_I_FRMERR = 3;
   localparam int ASP_I_OVERRUN = 4;
   localparam int ASP_I_WAKE = 5;
   localparam int ASP_I_DCD = 6;
   localparam int ASP_NIRQ = 7;
   localparam int ASP_CLK_HZ = 100000000;
   localparam int ASP_DEF_BAUD = 9600;
   localparam int ASP_MIN_DIV = 8;
   localparam logic [19:0] ASP_DIV_RST = 20'(ASP_CLK_HZ / ASP_DEF_BAUD);
   typedef enum logic [2:0] {ASP_T_IDLE, ASP_T_LEAD, ASP_T_START, ASP_T_DATA, ASP_T_PAR,
      ASP_T_STOP, ASP_T_TRAIL} asp_tx_t;
   typedef enum logic [2:0] {ASP_R_IDLE, ASP_R_START, ASP_R_DATA, ASP_R_PAR,
      ASP_R_STOP} asp_rx_t;
endpackage : asp_pkg

//--- verilog/asp_uart.sv
// Purpose: UART with RTS/CTS, modem lines, RS485 enable and AXI4-Lite registers
// Assumes: All serial and modem inputs are asynchronous and synchronised here
// Notes: Single clock; bit timing from a programmable divider
//
// Chosen here: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
// Operation
// - Bit rates span 95 baud to 12.5 Mbaud at 100 MHz through the divider register.
// - The divider never runs below eight system clocks per bit.
// - Peak rate is the system clock over eight, e.g. 6 Mbaud at 48 MHz.
// - A frame is start bit, seven or eight data bits, optional parity, one or two stops.
// - Data bits go out and come in least significant bit first.
// - Reset leaves 9600 baud, RTS/CTS flow, eight bits, no parity, one stop.
// - Transmit-active rises one bit before the start bit and falls one bit after the last.
// - Transmit-active stays high through the whole transmission.
// - Serial data leaves on the transmit pin and is sampled from the receive pin.
// - Request-to-send is driven as flow indication when flow control is on.
// - Data-terminal-ready is an active-low output under software control.
// - Ring indicate can wake the block from sleep when that wake is enabled.
module asp_uart
   import asp_pkg::*;
(
   input wire logic CLOCK,
   input wire logic RESET,
   input wire logic [7:0] S_AXI_AWADDR,
   input wire logic S_AXI_AWVALID,
   output logic S_AXI_AWREADY,
   input wire logic [31:0] S_AXI_WDATA,
   input wire logic [3:0] S_AXI_WSTRB,
   input wire logic S_AXI_WVALID,
   output logic S_AXI_WREADY,
   output logic [1:0] S_AXI_BRESP,
   output logic S_AXI_BVALID,
   input wire logic S_AXI_BREADY,
   input wire logic [7:0] S_AXI_ARADDR,
   input wire logic S_AXI_ARVALID,
   output logic S_AXI_ARREADY,
   output logic [31:0] S_AXI_RDATA,
   output logic [1:0] S_AXI_RRESP,
   output logic S_AXI_RVALID,
   input wire logic S_AXI_RREADY,
   output logic TXD,
   input wire logic RXD,
   output logic RTS_N,
   input wire logic CTS_N,
   output logic DTR_N,
   input wire logic DCD_N,
   input wire logic RING_INDICATE_N,
   output logic TX_ACTIVE,
   output logic IRQ
);
   // Synchronisers: stage 1 is read only by stage 2
   logic [3:0] sync1_reg;
   logic [3:0] sync2_reg;
   always_ff @(posedge CLOCK)
   begin
      if (RESET)
      begin
         sync1_reg <= 4'hf;
         sync2_reg <= 4'hf;
      end
      else
      begin
         sync1_reg <= {RING_INDICATE_N, DCD_N, CTS_N, RXD};
         sync2_reg <= sync1_reg;
      end
   end
   wire rxd_s = sync2_reg[0];
   wire cts_s = ~sync2_reg[1];
   wire dcd_s = ~sync2_reg[2];
   wire ri_s = ~sync2_reg[3];

   // Registers
   logic [8:0] ctrl_reg;
   logic [19:0] div_reg;
   logic [ASP_NIRQ-1:0] irq_reg;
   logic [ASP_NIRQ-1:0] mask_reg;
   logic [7:0] txbuf_reg;
   logic txfull_reg;
   logic [7:0] rxbuf_reg;
   logic rxfull_reg;
   logic dcd_prev_reg;

   wire bits7 = ctrl_reg[ASP_C_BITS7];
   wire par_en = ctrl_reg[ASP_C_PAR_EN];
   wire par_odd = ctrl_reg[ASP_C_PAR_ODD];
   wire stop2 = ctrl_reg[ASP_C_STOP2];
   wire flow_en = ctrl_reg[ASP_C_FLOW];
   wire sleeping = ctrl_reg[ASP_C_SLEEP];
   wire [2:0] last_bit = bits7 ? 3'd6 : 3'd7;

   // AXI write path: address and data latched in either order
   logic aw_got_reg;
   logic w_got_reg;
   logic [7:0] awaddr_reg;
   logic [31:0] wdata_reg;
   logic [3:0] wstrb_reg;
   wire wr_go = aw_got_reg & w_got_reg & ~S_AXI_BVALID;
   wire wr_ctrl = wr_go & (awaddr_reg == ASP_CTRL_OFS) & wstrb_reg[0];
   wire wr_ctrl_hi = wr_go & (awaddr_reg == ASP_CTRL_OFS) & wstrb_reg[1];
   wire wr_baud = wr_go & (awaddr_reg == ASP_BAUD_OFS);
   wire wr_tx = wr_go & (awaddr_reg == ASP_TXDATA_OFS) & wstrb_reg[0];
   wire wr_irq = wr_go & (awaddr_reg == ASP_IRQ_OFS) & wstrb_reg[0];
   wire wr_mask = wr_go & (awaddr_reg == ASP_MASK_OFS) & wstrb_reg[0];
   wire wr_ok = (awaddr_reg <= ASP_MASK_OFS) & (awaddr_reg[1:0] == 2'b00);
   // Divider kept legal; a lower value is clamped at the minimum
   wire [19:0] wdiv = {wstrb_reg[2] ? wdata_reg[19:16] : div_reg[19:16],
      wstrb_reg[1] ? wdata_reg[15:8] : div_reg[15:8],
      wstrb_reg[0] ? wdata_reg[7:0] : div_reg[7:0]};
   wire [19:0] div_new = (wdiv < 20'(ASP_MIN_DIV)) ? 20'(ASP_MIN_DIV) : wdiv;

   always_ff @(posedge CLOCK)
   begin
      if (RESET)
      begin
         aw_got_reg <= 1'b0;
         w_got_reg <= 1'b0;
         awaddr_reg <= 8'h00;
         wdata_reg <= 32'h0;
         wstrb_reg <= 4'h0;
         S_AXI_BVALID <= 1'b0;
         S_AXI_BRESP <= 2'b00;
      end
      else
      begin
         if (S_AXI_AWVALID & S_AXI_AWREADY)
         begin
            aw_got_reg <= 1'b1;
            awaddr_reg <= S_AXI_AWADDR;
         end
         if (S_AXI_WVALID & S_AXI_WREADY)
         begin
            w_got_reg <= 1'b1;
            wdata_reg <= S_AXI_WDATA;
            wstrb_reg <= S_AXI_WSTRB;
         end
         if (wr_go)
         begin
            aw_got_reg <= 1'b0;
            w_got_reg <= 1'b0;
            S_AXI_BVALID <= 1'b1;
            S_AXI_BRESP <= wr_ok ? 2'b00 : 2'b10;
         end
         else if (S_AXI_BREADY)
            S_AXI_BVALID <= 1'b0;
      end
   end
   assign S_AXI_AWREADY = ~aw_got_reg & ~S_AXI_BVALID;
   assign S_AXI_WREADY = ~w_got_reg & ~S_AXI_BVALID;

   // AXI read path
   wire rd_go = S_AXI_ARVALID & S_AXI_ARREADY;
   wire rd_rx = rd_go & (S_AXI_ARADDR == ASP_RXDATA_OFS);
   wire [31:0] stat_word = {25'h0, dcd_s, cts_s, rxfull_reg, txfull_reg, TX_ACTIVE,
      sleeping, rxd_s};
   logic [31:0] rd_word;
   logic rd_bad;
   always_comb
   begin
      rd_bad = 1'b0;
      unique case (S_AXI_ARADDR)
         ASP_CTRL_OFS: rd_word = {23'h0, ctrl_reg};
         ASP_BAUD_OFS: rd_word = {12'h0, div_reg};
         ASP_TXDATA_OFS: rd_word = {24'h0, txbuf_reg};
         ASP_RXDATA_OFS: rd_word = {24'h0, rxbuf_reg};
         ASP_STAT_OFS: rd_word = stat_word;
         ASP_IRQ_OFS: rd_word = {25'h0, irq_reg};
         ASP_MASK_OFS: rd_word = {25'h0, mask_reg};
         default:
         begin
            rd_word = 32'h0;
            rd_bad = 1'b1;
         end
      endcase
   end
   always_ff @(posedge CLOCK)
   begin
      if (RESET)
      begin
         S_AXI_RVALID <= 1'b0;
         S_AXI_RDATA <= 32'h0;
         S_AXI_RRESP <= 2'b00;
      end
      else if (rd_go)
      begin
         S_AXI_RVALID <= 1'b1;
         S_AXI_RDATA <= rd_word;
         S_AXI_RRESP <= rd_bad ? 2'b10 : 2'b00;
      end
      else if (S_AXI_RREADY)
         S_AXI_RVALID <= 1'b0;
   end
   assign S_AXI_ARREADY = ~S_AXI_RVALID;

   // Transmitter
   asp_tx_t tx_state_reg;
   logic [19:0] tx_cnt_reg;
   logic [2:0] tx_idx_reg;
   logic [7:0] tx_sh_reg;
   logic tx_par_reg;
   logic tx_stop_reg;
   wire tx_tick = (tx_cnt_reg == div_reg - 20'd1);
   // Flow control gates only the start of a new frame
   wire tx_start = txfull_reg & (~flow_en | cts_s) & ~sleeping;
   logic tx_done;
   always_ff @(posedge CLOCK)
   begin
      if (RESET)
      begin
         tx_state_reg <= ASP_T_IDLE;
         tx_cnt_reg <= 20'h0;
         tx_idx_reg <= 3'd0;
         tx_sh_reg <= 8'h00;
         tx_par_reg <= 1'b0;
         tx_stop_reg <= 1'b0;
         TXD <= 1'b1;
         TX_ACTIVE <= 1'b0;
         tx_done <= 1'b0;
      end
      else
      begin
         tx_done <= 1'b0;
         tx_cnt_reg <= (tx_state_reg == ASP_T_IDLE || tx_tick) ? 20'h0 : tx_cnt_reg + 20'd1;
         unique case (tx_state_reg)
            ASP_T_IDLE:
               if (tx_start)
               begin
                  tx_state_reg <= ASP_T_LEAD;
                  tx_sh_reg <= txbuf_reg;
                  tx_par_reg <= par_odd;
                  TX_ACTIVE <= 1'b1;
               end
            ASP_T_LEAD:
               if (tx_tick)
               begin
                  tx_state_reg <= ASP_T_START;
                  TXD <= 1'b0;
               end
            ASP_T_START:
               if (tx_tick)
               begin
                  tx_state_reg <= ASP_T_DATA;
                  tx_idx_reg <= 3'd0;
                  TXD <= tx_sh_reg[0];
                  tx_par_reg <= tx_par_reg ^ tx_sh_reg[0];
                  tx_sh_reg <= {1'b0, tx_sh_reg[7:1]};
               end
            ASP_T_DATA:
               if (tx_tick)
               begin
                  if (tx_idx_reg == last_bit)
                  begin
                     tx_state_reg <= par_en ? ASP_T_PAR : ASP_T_STOP;
                     TXD <= par_en ? tx_par_reg : 1'b1;
                     tx_stop_reg <= stop2;
                  end
                  else
                  begin
                     tx_idx_reg <= tx_idx_reg + 3'd1;
                     TXD <= tx_sh_reg[0];
                     tx_par_reg <= tx_par_reg ^ tx_sh_reg[0];
                     tx_sh_reg <= {1'b0, tx_sh_reg[7:1]};
                  end
               end
            ASP_T_PAR:
               if (tx_tick)
               begin
                  tx_state_reg <= ASP_T_STOP;
                  TXD <= 1'b1;
                  tx_stop_reg <= stop2;
               end
            ASP_T_STOP:
               if (tx_tick)
               begin
                  tx_stop_reg <= 1'b0;
                  if (!tx_stop_reg)
                     tx_state_reg <= ASP_T_TRAIL;
               end
            ASP_T_TRAIL:
               if (tx_tick)
               begin
                  tx_state_reg <= ASP_T_IDLE;
                  TX_ACTIVE <= 1'b0;
                  tx_done <= 1'b1;
               end
         endcase
      end
   end

   // Receiver
   asp_rx_t rx_state_reg;
   logic [19:0] rx_cnt_reg;
   logic [2:0] rx_idx_reg;
   logic [7:0] rx_sh_reg;
   logic rx_par_reg;
   wire [19:0] half_div = {1'b0, div_reg[19:1]};
   wire rx_mid = (rx_state_reg == ASP_R_START) ? (rx_cnt_reg == half_div) :
      (rx_cnt_reg == div_reg - 20'd1);
   logic rx_done;
   logic rx_perr;
   logic rx_ferr;
   always_ff @(posedge CLOCK)
   begin
      if (RESET)
      begin
         rx_state_reg <= ASP_R_IDLE;
         rx_cnt_reg <= 20'h0;
         rx_idx_reg <= 3'd0;
         rx_sh_reg <= 8'h00;
         rx_par_reg <= 1'b0;
         rx_done <= 1'b0;
         rx_perr <= 1'b0;
         rx_ferr <= 1'b0;
      end
      else
      begin
         rx_done <= 1'b0;
         rx_ferr <= 1'b0;
         rx_cnt_reg <= (rx_state_reg == ASP_R_IDLE || rx_mid) ? 20'h0 : rx_cnt_reg + 20'd1;
         unique case (rx_state_reg)
            ASP_R_IDLE:
               if (!rxd_s && !sleeping)
                  rx_state_reg <= ASP_R_START;
            ASP_R_START:
               if (rx_mid)
               begin
                  rx_state_reg <= rxd_s ? ASP_R_IDLE : ASP_R_DATA;
                  rx_idx_reg <= 3'd0;
                  rx_par_reg <= par_odd;
                  rx_sh_reg <= 8'h00;
               end
            ASP_R_DATA:
               if (rx_mid)
               begin
                  rx_sh_reg <= {rxd_s, rx_sh_reg[7:1]};
                  rx_par_reg <= rx_par_reg ^ rxd_s;
                  rx_idx_reg <= rx_idx_reg + 3'd1;
                  if (rx_idx_reg == last_bit)
                     rx_state_reg <= par_en ? ASP_R_PAR : ASP_R_STOP;
               end
            ASP_R_PAR:
               if (rx_mid)
               begin
                  rx_par_reg <= rx_par_reg ^ rxd_s;
                  rx_state_reg <= ASP_R_STOP;
               end
            ASP_R_STOP:
               if (rx_mid)
               begin
                  // Early return to idle leaves half a bit to catch the next start
                  rx_state_reg <= ASP_R_IDLE;
                  rx_done <= 1'b1;
                  rx_ferr <= ~rxd_s;
                  rx_perr <= par_en & rx_par_reg;
               end
         endcase
      end
   end
   // Seven-bit frames arrive shifted one place too high
   wire [7:0] rx_word = bits7 ? {1'b0, rx_sh_reg[7:1]} : rx_sh_reg;

   // Data buffers, control and modem inputs
   wire rd_take = rd_rx;
   always_ff @(posedge CLOCK)
   begin
      if (RESET)
      begin
         ctrl_reg <= ASP_CTRL_RST;
         div_reg <= ASP_DIV_RST;
         mask_reg <= '0;
         txbuf_reg <= 8'h00;
         txfull_reg <= 1'b0;
         rxbuf_reg <= 8'h00;
         rxfull_reg <= 1'b0;
         dcd_prev_reg <= 1'b0;
      end
      else
      begin
         dcd_prev_reg <= dcd_s;
         if (wr_ctrl)
            ctrl_reg[7:0] <= wdata_reg[7:0];
         if (wr_ctrl_hi)
            ctrl_reg[8] <= wdata_reg[8];
         if (ri_s && ctrl_reg[ASP_C_RI_WAKE])
            ctrl_reg[ASP_C_SLEEP] <= 1'b0;
         if (wr_baud)
            div_reg <= div_new;
         if (wr_mask)
            mask_reg <= wdata_reg[ASP_NIRQ-1:0];
         if (wr_tx && !txfull_reg)
         begin
            txbuf_reg <= wdata_reg[7:0];
            txfull_reg <= 1'b1;
         end
         else if (tx_state_reg == ASP_T_IDLE && tx_start)
            txfull_reg <= 1'b0;
         if (rx_done)
         begin
            rxbuf_reg <= rx_word;
            rxfull_reg <= 1'b1;
         end
         else if (rd_take)
            rxfull_reg <= 1'b0;
      end
   end

   // Sticky events, set wins over a write-one clear
   wire [ASP_NIRQ-1:0] ev = {dcd_s ^ dcd_prev_reg, ri_s & ctrl_reg[ASP_C_RI_WAKE] & sleeping,
      rx_done & rxfull_reg & ~rd_take, rx_ferr, rx_done & rx_perr, tx_done,
      rx_done};
   wire [ASP_NIRQ-1:0] clr = wr_irq ? wdata_reg[ASP_NIRQ-1:0] : '0;
   always_ff @(posedge CLOCK)
   begin
      if (RESET)
      begin
         irq_reg <= '0;
         IRQ <= 1'b0;
         RTS_N <= 1'b1;
         DTR_N <= 1'b1;
      end
      else
      begin
         irq_reg <= (irq_reg & ~clr) | ev;
         IRQ <= |(((irq_reg & ~clr) | ev) & mask_reg);
         // Flow on: ready while a received byte has room; off: software level
         RTS_N <= flow_en ? rxfull_reg : ~ctrl_reg[ASP_C_RTS];
         DTR_N <= ~ctrl_reg[ASP_C_DTR];
      end
   end
endmodule : asp_uart

//--- testbench/asp_uart_monitor.sv
// Purpose: Port-level checks for the serial port
// Assumes: Bit period of at least eight clocks
// Notes: Bound to every asp_uart instance
`timescale 1ns/10ps
module asp_uart_monitor (
   input wire logic CLOCK,
   input wire logic RESET,
   input wire logic S_AXI_AWVALID,
   input wire logic S_AXI_AWREADY,
   input wire logic S_AXI_WVALID,
   input wire logic S_AXI_WREADY,
   input wire logic S_AXI_BVALID,
   input wire logic S_AXI_BREADY,
   input wire logic S_AXI_ARVALID,
   input wire logic S_AXI_ARREADY,
   input wire logic S_AXI_RVALID,
   input wire logic S_AXI_RREADY,
   input wire logic TXD,
   input wire logic TX_ACTIVE
);
   logic [4:0] hi_cnt_reg;
   default clocking @(posedge CLOCK);
   endclocking
   default disable iff (RESET);
   // Saturating run of high samples, so stop plus trail can be measured
   always_ff @(posedge CLOCK)
   begin
      if (RESET || !TXD)
         hi_cnt_reg <= 5'h00;
      else if (hi_cnt_reg != 5'h1f)
         hi_cnt_reg <= hi_cnt_reg + 5'h01;
   end
   sequence lead_s;
      TXD [*8];
   endsequence
   sequence bit_hold_s;
      $stable(TXD) [*7];
   endsequence
   aw_block_a: assert property (S_AXI_BVALID |-> !S_AXI_AWREADY && !S_AXI_WREADY)
      else $error("write channel open while a response waits");
   b_answer_a: assert property (S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID
      && S_AXI_WREADY |-> ##[1:2] S_AXI_BVALID) else $error("write response late");
   b_release_a: assert property (S_AXI_BVALID && S_AXI_BREADY |=> !S_AXI_BVALID)
      else $error("write response held after acceptance");
   r_answer_a: assert property (S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID)
      else $error("read data late");
   r_release_a: assert property (S_AXI_RVALID && S_AXI_RREADY |=> !S_AXI_RVALID)
      else $error("read data held after acceptance");
   tx_lead_a: assert property ($rose(TX_ACTIVE) |-> lead_s)
      else $error("line left idle too soon after enable");
   tx_idle_a: assert property (!TX_ACTIVE |-> TXD)
      else $error("line driven while enable is low");
   bit_min_a: assert property ($changed(TXD) |=> bit_hold_s)
      else $error("bit shorter than eight clocks");
   tx_trail_a: assert property ($fell(TX_ACTIVE) |-> hi_cnt_reg >= 5'h10)
      else $error("enable dropped without stop and trailing bit");
   tx_start_a: assert property ($fell(TXD) |-> $past(TX_ACTIVE))
      else $error("start bit without leading enable");
endmodule : asp_uart_monitor
bind asp_uart asp_uart_monitor i_mon (
   .CLOCK(CLOCK),
   .RESET(RESET),
   .S_AXI_AWVALID(S_AXI_AWVALID),
   .S_AXI_AWREADY(S_AXI_AWREADY),
   .S_AXI_WVALID(S_AXI_WVALID),
   .S_AXI_WREADY(S_AXI_WREADY),
   .S_AXI_BVALID(S_AXI_BVALID),
   .S_AXI_BREADY(S_AXI_BREADY),
   .S_AXI_ARVALID(S_AXI_ARVALID),
   .S_AXI_ARREADY(S_AXI_ARREADY),
   .S_AXI_RVALID(S_AXI_RVALID),
   .S_AXI_RREADY(S_AXI_RREADY),
   .TXD(TXD),
   .TX_ACTIVE(TX_ACTIVE)
);

//--- testbench/asp_serial_peer.sv
// Purpose: Behavioural remote serial device
// Assumes: Bench sets bit period and frame format before traffic
// Notes: Receive line idles high between frames, as a marking line does
`timescale 1ns/10ps
module asp_serial_peer (
   input wire logic CLOCK,
   input wire logic TXD,
   output logic RXD,
   output logic CTS_N,
   output logic DCD_N,
   output logic RING_INDICATE_N
);
   int div = 8;
   int nb = 8;
   bit pe, po, s2;
   logic [7:0] got, v;
   logic got_par;
   logic [1:0] got_stop;
   initial
   begin
      RXD = 1'b1;
      CTS_N = 1'b0;
      DCD_N = 1'b1;
      RING_INDICATE_N = 1'b1;
   end
   task automatic bit_out(input logic b);
      RXD <= b;
      repeat (div) @(posedge CLOCK);
   endtask : bit_out
   // Breaks parity or stop only when the bench asks
   task automatic send(input logic [7:0] d, input bit bad_par, input bit bad_stop);
      logic [7:0] m;
      m = (nb == 7) ? (d & 8'h7f) : d;
      @(posedge CLOCK);
      bit_out(1'b0);
      for (int i = 0; i < nb; i++)
         bit_out(m[i]);
      if (pe)
         bit_out(^m ^ po ^ bad_par);
      bit_out(!bad_stop);
      if (s2)
         bit_out(1'b1);
      RXD <= 1'b1;
   endtask : send
   // Centre sampling of the port's line
   always
   begin
      @(negedge TXD);
      repeat (div / 2) @(posedge CLOCK);
      v = 8'h00;
      got_par = 1'b0;
      got_stop = 2'h3;
      for (int i = 0; i < nb; i++)
      begin
         repeat (div) @(posedge CLOCK);
         v[i] = TXD;
      end
      if (pe)
      begin
         repeat (div) @(posedge CLOCK);
         got_par = TXD;
      end
      repeat (div) @(posedge CLOCK);
      got_stop[0] = TXD;
      if (s2)
      begin
         repeat (div) @(posedge CLOCK);
         got_stop[1] = TXD;
      end
      got = v;
   end
endmodule : asp_serial_peer

//--- testbench/testbench.sv
// Purpose: Register-level tests of the serial port against a remote peer
// Assumes: Divider at its floor of eight clocks per bit
// Notes: Errors, wake and carrier are driven through the peer
`timescale 1ns/10ps
module testbench
   import asp_pkg::*;
;
   logic clock = 1'b0;
   logic reset = 1'b1;
   logic [7:0] aw_addr = 8'h00, ar_addr = 8'h00, d, m;
   logic aw_valid = 1'b0, w_valid = 1'b0, b_ready = 1'b0, ar_valid = 1'b0, r_ready = 1'b0;
   logic aw_ready, w_ready, b_valid, ar_ready, r_valid, txd, rxd, rts_n, cts_n;
   logic dtr_n, dcd_n, ri_n, tx_active, irq;
   logic [1:0] b_resp, r_resp, resp;
   logic [31:0] w_data = 32'h0, r_data, rd_data;
   logic [8:0] c;
   logic [8:0] cfg_tab [4] = '{9'h010, 9'h013, 9'h016, 9'h019};
   int error_cnt = 0, n_compared = 0, act_cnt = 0;
   always #5 clock = ~clock;
   always @(posedge clock)
      if (tx_active)
         act_cnt <= act_cnt + 1;
   asp_uart i_dut (.CLOCK(clock), .RESET(reset), .S_AXI_AWADDR(aw_addr),
      .S_AXI_AWVALID(aw_valid), .S_AXI_AWREADY(aw_ready), .S_AXI_WDATA(w_data),
      .S_AXI_WSTRB(4'hf), .S_AXI_WVALID(w_valid), .S_AXI_WREADY(w_ready),
      .S_AXI_BRESP(b_resp), .S_AXI_BVALID(b_valid), .S_AXI_BREADY(b_ready),
      .S_AXI_ARADDR(ar_addr), .S_AXI_ARVALID(ar_valid), .S_AXI_ARREADY(ar_ready),
      .S_AXI_RDATA(r_data), .S_AXI_RRESP(r_resp), .S_AXI_RVALID(r_valid),
      .S_AXI_RREADY(r_ready), .TXD(txd), .RXD(rxd), .RTS_N(rts_n), .CTS_N(cts_n),
      .DTR_N(dtr_n), .DCD_N(dcd_n), .RING_INDICATE_N(ri_n), .TX_ACTIVE(tx_active),
      .IRQ(irq));
   asp_serial_peer i_peer (.CLOCK(clock), .TXD(txd), .RXD(rxd), .CTS_N(cts_n),
      .DCD_N(dcd_n), .RING_INDICATE_N(ri_n));
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   // No local limit: only the watchdog ends a stalled transfer
   task automatic wr(input logic [7:0] a, input logic [31:0] dv);
      @(posedge clock);
      aw_addr <= a;
      w_data <= dv;
      aw_valid <= 1'b1;
      w_valid <= 1'b1;
      b_ready <= 1'b1;
      do
      begin
         @(posedge clock);
         if (aw_ready)
            aw_valid <= 1'b0;
         if (w_ready)
            w_valid <= 1'b0;
      end
      while (!b_valid);
      resp = b_resp;
      b_ready <= 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a);
      @(posedge clock);
      ar_addr <= a;
      ar_valid <= 1'b1;
      r_ready <= 1'b1;
      do
      begin
         @(posedge clock);
         if (ar_ready)
            ar_valid <= 1'b0;
      end
      while (!r_valid);
      rd_data = r_data;
      resp = r_resp;
      r_ready <= 1'b0;
   endtask : rd
   task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
      rd(a);
      chk(rd_data, exp);
   endtask : rdc
   // Counts enable-high cycles of one frame
   task automatic txw(input int len);
      int n = 0;
      while ((act_cnt == 0 || tx_active) && n < 999)
      begin
         @(posedge clock);
         n++;
      end
      chk(act_cnt, len);
   endtask : txw
   task final_report;
      $display("compared %0d, mismatches %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : final_report
   initial
   begin
      #300000;
      error_cnt++;
      $display("mismatch at %0t: watchdog expired", $time);
      final_report();
   end
   initial
   begin
      repeat (3) @(posedge clock);
      reset <= 1'b0;
      rdc(ASP_CTRL_OFS, 32'(ASP_CTRL_RST));
      rdc(ASP_BAUD_OFS, 32'(ASP_CLK_HZ / 9600));
      rdc(ASP_MASK_OFS, 32'h0);
      chk(32'({rts_n, dtr_n, txd, tx_active, irq}), 32'h0c);
      rd(8'h1c);
      chk(32'(resp), 32'h2);
      wr(8'h1c, 32'h0);
      chk(32'(resp), 32'h2);
      wr(ASP_BAUD_OFS, 32'h85690);
      rdc(ASP_BAUD_OFS, 32'h85690);
      i_peer.CTS_N <= 1'b1;
      act_cnt <= 0;
      wr(ASP_BAUD_OFS, 32'h4);
      rdc(ASP_BAUD_OFS, 32'(ASP_MIN_DIV));
      wr(ASP_TXDATA_OFS, 32'h5a);
      repeat (40) @(posedge clock);
      chk(32'(tx_active), 32'h0);
      i_peer.CTS_N <= 1'b0;
      txw(96);
      chk(32'(i_peer.got), 32'h5a);
      wr(ASP_MASK_OFS, 32'h2);
      rdc(ASP_IRQ_OFS, 32'h2);
      chk(32'(irq), 32'h1);
      wr(ASP_IRQ_OFS, 32'h2);
      rdc(ASP_IRQ_OFS, 32'h0);
      chk(32'(irq), 32'h0);
      for (int i = 0; i < 4; i++)
      begin
         c = cfg_tab[i];
         wr(ASP_CTRL_OFS, 32'(c));
         i_peer.nb = c[0] ? 7 : 8;
         {i_peer.s2, i_peer.po, i_peer.pe} = c[3:1];
         m = c[0] ? 8'h7f : 8'hff;
         d = 8'hb4 + 8'(i);
         i_peer.send(d, 1'b0, 1'b0);
         rdc(ASP_RXDATA_OFS, 32'(d & m));
         act_cnt <= 0;
         wr(ASP_TXDATA_OFS, 32'(~d));
         txw(8 * (i_peer.nb + 4 + int'(c[1]) + int'(c[3])));
         chk(32'(i_peer.got), 32'(~d & m));
         chk(32'(i_peer.got_par), c[1] ? 32'(^(~d & m) ^ c[2]) : 32'h0);
         chk(32'(i_peer.got_stop), 32'h3);
      end
      wr(ASP_CTRL_OFS, 32'h016);
      i_peer.nb = 8;
      {i_peer.s2, i_peer.po, i_peer.pe} = 3'b011;
      wr(ASP_IRQ_OFS, 32'h7f);
      i_peer.send(8'h11, 1'b0, 1'b0);
      rd(ASP_STAT_OFS);
      chk(32'({rd_data[4], rts_n}), 32'h3);
      i_peer.send(8'h22, 1'b0, 1'b0);
      rd(ASP_IRQ_OFS);
      chk(32'(rd_data[4]), 32'h1);
      rd(ASP_RXDATA_OFS);
      wr(ASP_IRQ_OFS, 32'h7f);
      chk(32'(rts_n), 32'h0);
      i_peer.send(8'h33, 1'b1, 1'b0);
      rd(ASP_IRQ_OFS);
      chk(32'(rd_data[2]), 32'h1);
      i_peer.send(8'h44, 1'b0, 1'b1);
      rd(ASP_IRQ_OFS);
      chk(32'(rd_data[3]), 32'h1);
      wr(ASP_CTRL_OFS, 32'h0f0);
      i_peer.DCD_N <= 1'b0;
      rd(ASP_STAT_OFS);
      chk(32'(rd_data[1]), 32'h1);
      i_peer.RING_INDICATE_N <= 1'b0;
      // Two synchroniser stages plus the wake edge before sleep clears
      repeat (4) @(posedge clock);
      rd(ASP_STAT_OFS);
      chk(32'({rd_data[6], rd_data[1]}), 32'h2);
      rd(ASP_IRQ_OFS);
      chk(32'(rd_data[6:5]), 32'h3);
      chk(32'(dtr_n), 32'h0);
      final_report();
   end
endmodule : testbench
